// file: pcrb_pkg.sv
// Package of register map, field layout and reset values for the control register bank
package pcrb_pkg;

    // ========================================
    // Register offsets
    localparam logic [7:0] OFS_POWER_BAD = 8'h01;
    localparam logic [7:0] OFS_FAULT_MASK = 8'h02;
    localparam logic [7:0] OFS_SUPPLY_ENABLE = 8'h03;
    localparam logic [7:0] OFS_CONV_MODE = 8'h04;
    localparam logic [7:0] OFS_CONV_CONTROL = 8'h05;

    // ========================================
    // Reset values loaded on undervoltage lockout
    localparam logic [7:0] RST_FAULT_MASK = 8'hC0;
    localparam logic [7:0] RST_SUPPLY_ENABLE = 8'hFF;
    localparam logic [7:0] RST_CONV_MODE = 8'hB1;
    localparam logic [7:0] RST_CONV_CONTROL = 8'h40;

    // ========================================
    // Field positions and masks
    localparam int BIT_CORE_EN = 5;
    localparam int BIT_BUCK2_EN = 4;
    localparam int BIT_BUCK3_EN = 3;
    localparam int BIT_LDO2_EN = 2;
    localparam int BIT_LDO1_EN = 1;
    localparam int BIT_GO = 7;
    localparam int BIT_CORE_ADJ = 6;
    localparam logic [7:0] FLAG_USED = 8'hFE;
    localparam logic [7:0] RAIL_USED = 8'h3E;
    localparam logic [7:0] CTRL_USED = 8'hC7;
    localparam logic [7:0] UNMAPPED_READ = 8'hFF;

    // Register write request from the serial engine
    typedef struct packed {
        logic strobe;
        logic [7:0] addr;
        logic [7:0] data;
    } pcrb_wr_t;

    // Converter mode fields as the analog side sees them
    typedef struct packed {
        logic [1:0] buck2Phase;
        logic [1:0] buck3Phase;
        logic lowRipple;
        logic forcedFixedFreqBuck2;
        logic forcedFixedFreqCore;
        logic forcedFixedFreqBuck3;
    } pcrb_mode_t;

endpackage : pcrb_pkg

// file: pcrb_bank.sv
// Control register bank: fault mask, supply enables, converter mode and control
`timescale 1ns/1ps
module pcrb_bank (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic supply_undervoltage_lockout,
    input wire logic warm_reset_pin_n,
    input wire logic power_on_reset_out,
    input wire logic backup_supply_low,
    input wire pcrb_pkg::pcrb_wr_t regWrite,
    input wire logic readStrobe,
    input wire logic [7:0] readAddr,
    output logic [7:0] readData_q,
    input wire logic core_buck_enable_pin,
    input wire logic buck_two_enable_pin,
    input wire logic buck_three_enable_pin,
    input wire logic linear_reg_enable_pin,
    input wire logic [7:0] railLowRaw,
    input wire logic power_fail_flag,
    input wire logic low_battery_flag,
    input wire logic targetCodeReached,
    input wire logic core_default_strap,
    output logic [7:0] railOn_q,
    output pcrb_pkg::pcrb_mode_t convMode_q,
    output logic dynamic_voltage_transition_q,
    output logic coreFromStrap_q,
    output logic coreStrapHigh_q,
    output logic [2:0] dischargeEn_q,
    output logic [7:0] power_bad_flags_q,
    output logic interruptOut_q,
    output logic interruptOe_q
);
    import pcrb_pkg::*;

    logic [7:0] faultMask_q;
    logic [7:0] supplyEnable_q;
    logic [7:0] convModeReg_q;
    logic [7:0] convControl_q;
    logic [7:0] pinVec;
    logic [7:0] flagsRaw;
    logic anyOn;
    logic faultAct;
    logic released_q;
    logic warmEvent;
    logic wrMask, wrEnable, wrMode, wrCtrl, rdFlags;

    // Decode of serial engine strobes
    assign wrMask = regWrite.strobe && regWrite.addr == OFS_FAULT_MASK;
    assign wrEnable = regWrite.strobe && regWrite.addr == OFS_SUPPLY_ENABLE;
    assign wrMode = regWrite.strobe && regWrite.addr == OFS_CONV_MODE;
    assign wrCtrl = regWrite.strobe && regWrite.addr == OFS_CONV_CONTROL;
    assign rdFlags = readStrobe && readAddr == OFS_POWER_BAD;
    assign warmEvent = supply_undervoltage_lockout || !warm_reset_pin_n
        || power_on_reset_out || backup_supply_low;

    // ========================================
    // Enable pins laid on register bit positions
    always_comb
    begin
        pinVec = 8'hFF;
        pinVec[BIT_CORE_EN] = core_buck_enable_pin;
        pinVec[BIT_BUCK2_EN] = buck_two_enable_pin;
        pinVec[BIT_BUCK3_EN] = buck_three_enable_pin;
        pinVec[BIT_LDO2_EN] = linear_reg_enable_pin;
        pinVec[BIT_LDO1_EN] = linear_reg_enable_pin;
    end

    // Power-bad flags: rails count only while switched on
    always_comb
    begin
        flagsRaw = (railLowRaw & railOn_q & RAIL_USED);
        flagsRaw[7] = power_fail_flag;
        flagsRaw[6] = low_battery_flag;
    end

    // ========================================
    // Fault mask register
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            faultMask_q <= RST_FAULT_MASK;
        else if (supply_undervoltage_lockout)
            faultMask_q <= RST_FAULT_MASK;
        else if (wrMask)
            faultMask_q <= regWrite.data & FLAG_USED;
    end

    // Supply enable register, pin low restores a bit to one
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            supplyEnable_q <= RST_SUPPLY_ENABLE;
        else if (supply_undervoltage_lockout)
            supplyEnable_q <= RST_SUPPLY_ENABLE;
        else if (wrEnable)
            supplyEnable_q <= (regWrite.data | ~RAIL_USED) | ~pinVec;
        else
            supplyEnable_q <= supplyEnable_q | ~pinVec;
    end

    // Rail on states from register AND pin
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            railOn_q <= 8'h00;
        else
            railOn_q <= supplyEnable_q & pinVec & RAIL_USED;
    end

    // ========================================
    // Converter mode register
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            convModeReg_q <= RST_CONV_MODE;
        else if (supply_undervoltage_lockout)
            convModeReg_q <= RST_CONV_MODE;
        else if (wrMode)
            convModeReg_q <= regWrite.data;
    end

    // Mode fields to converters
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            convMode_q <= pcrb_mode_t'(RST_CONV_MODE);
        else
            convMode_q <= pcrb_mode_t'(convModeReg_q);
    end

    // ========================================
    // Converter control register
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            convControl_q <= RST_CONV_CONTROL;
        else if (supply_undervoltage_lockout)
            convControl_q <= RST_CONV_CONTROL;
        else
        begin
            if (wrCtrl)
                convControl_q <= regWrite.data & CTRL_USED;
            if (targetCodeReached && !(wrCtrl && regWrite.data[BIT_GO]))
                convControl_q[BIT_GO] <= 1'b0;
            if (warmEvent)
                convControl_q[BIT_CORE_ADJ] <= 1'b1;
        end
    end

    // Control outputs to converters
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dynamic_voltage_transition_q <= 1'b0;
            coreFromStrap_q <= 1'b1;
            coreStrapHigh_q <= 1'b0;
            dischargeEn_q <= 3'h0;
        end
        else
        begin
            dynamic_voltage_transition_q <= convControl_q[BIT_GO];
            coreFromStrap_q <= convControl_q[BIT_CORE_ADJ];
            coreStrapHigh_q <= core_default_strap;
            dischargeEn_q <= convControl_q[2:0];
        end
    end

    // ========================================
    // Status flags and interrupt pin
    assign anyOn = |(supplyEnable_q & pinVec & RAIL_USED);
    assign faultAct = |(flagsRaw & ~faultMask_q & FLAG_USED);

    // Release after a status read, rearm once faults clear
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            released_q <= 1'b0;
        else if (rdFlags && interruptOe_q)
            released_q <= 1'b1;
        else if (!faultAct && anyOn)
            released_q <= 1'b0;
    end

    // Open-drain interrupt: drive low or float
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            interruptOe_q <= 1'b0;
            interruptOut_q <= 1'b0;
            power_bad_flags_q <= 8'h00;
        end
        else
        begin
            interruptOut_q <= 1'b0;
            interruptOe_q <= !anyOn || (faultAct && !released_q
                && !(rdFlags && interruptOe_q));
            power_bad_flags_q <= flagsRaw;
        end
    end

    // ========================================
    // Read mux
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            readData_q <= 8'h00;
        else if (readStrobe)
        begin
            case (readAddr)
                OFS_POWER_BAD: readData_q <= flagsRaw;
                OFS_FAULT_MASK: readData_q <= faultMask_q;
                OFS_SUPPLY_ENABLE: readData_q <= supplyEnable_q;
                OFS_CONV_MODE: readData_q <= convModeReg_q;
                OFS_CONV_CONTROL: readData_q <= convControl_q;
                default: readData_q <= UNMAPPED_READ;
            endcase
        end
    end

    // ========================================
    // Checks
    property p_lockMask;
        @(posedge clock) disable iff (!reset_n)
        supply_undervoltage_lockout |=> faultMask_q == RST_FAULT_MASK;
    endproperty
    a_lockMask: assert property (p_lockMask) else $error("mask not C0 after lockout");

    property p_lockEn;
        @(posedge clock) disable iff (!reset_n)
        supply_undervoltage_lockout |=> supplyEnable_q == RST_SUPPLY_ENABLE;
    endproperty
    a_lockEn: assert property (p_lockEn) else $error("enable not FF after lockout");

    property p_pinLow;
        @(posedge clock) disable iff (!reset_n)
        !core_buck_enable_pin |=> supplyEnable_q[BIT_CORE_EN] && !railOn_q[BIT_CORE_EN];
    endproperty
    a_pinLow: assert property (p_pinLow) else $error("pin low did not restore bit");

    property p_railAnd;
        @(posedge clock) disable iff (!reset_n)
        1'b1 |=> railOn_q[4] == ($past(supplyEnable_q[4]) && $past(buck_two_enable_pin));
    endproperty
    a_railAnd: assert property (p_railAnd) else $error("rail state not AND");

    property p_lockMode;
        @(posedge clock) disable iff (!reset_n)
        supply_undervoltage_lockout |=> ##1 convMode_q == pcrb_mode_t'(RST_CONV_MODE);
    endproperty
    a_lockMode: assert property (p_lockMode) else $error("mode not B1 after lockout");

    property p_goClear;
        @(posedge clock) disable iff (!reset_n)
        targetCodeReached && !wrCtrl && !supply_undervoltage_lockout |=> !convControl_q[7];
    endproperty
    a_goClear: assert property (p_goClear) else $error("go not cleared");

    property p_coreAdj;
        @(posedge clock) disable iff (!reset_n)
        !warm_reset_pin_n |=> convControl_q[6] ##1 coreFromStrap_q;
    endproperty
    a_coreAdj: assert property (p_coreAdj) else $error("core adjust not restored");

    property p_noneOn;
        @(posedge clock) disable iff (!reset_n)
        !anyOn |=> interruptOe_q;
    endproperty
    a_noneOn: assert property (p_noneOn) else $error("interrupt not low with no rail");

    property p_unused;
        @(posedge clock) disable iff (!reset_n)
        1'b1 |-> convControl_q[5:3] == 3'h0 && faultMask_q[0] == 1'b0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused bits set");

    // A status read with a rail on lets the pin float on the next cycle
    property p_readRelease;
        @(posedge clock) disable iff (!reset_n)
        rdFlags && interruptOe_q && anyOn |=> !interruptOe_q;
    endproperty
    a_readRelease: assert property (p_readRelease) else $error("read did not release");

    // A switched-off regulator never reports a power-bad flag
    property p_ldoFlag;
        @(posedge clock) disable iff (!reset_n)
        !railOn_q[BIT_LDO1_EN] |=> !power_bad_flags_q[BIT_LDO1_EN];
    endproperty
    a_ldoFlag: assert property (p_ldoFlag) else $error("flag set for rail off");

endmodule : pcrb_bank

// file: pcrb_host.sv
// Host model issuing register writes and reads to the control register bank
`timescale 1ns/1ps
module pcrb_host (
    input wire logic clock,
    output pcrb_pkg::pcrb_wr_t regWrite,
    output logic readStrobe,
    output logic [7:0] readAddr
);
    import pcrb_pkg::*;
    // ========================================
    // Idle bus at time zero
    initial
    begin
        regWrite = '0;
        readStrobe = 1'b0;
        readAddr = 8'h00;
    end
    // One-cycle write pulse; released fields show the inverse value
    task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regWrite <= '{1'b1, a, d};
        @(posedge clock);
        regWrite <= '{1'b0, ~a, ~d};
        repeat (2) @(posedge clock);
    endtask : writeReg
    // One-cycle read pulse, then idle while the answer settles
    task automatic readReg(input logic [7:0] a);
        @(posedge clock);
        readStrobe <= 1'b1;
        readAddr <= a;
        @(posedge clock);
        readStrobe <= 1'b0;
        readAddr <= ~a;
        repeat (2) @(posedge clock);
    endtask : readReg
endmodule : pcrb_host

// file: test_pcrb_bank.sv
// Self-checking testbench for the control register bank
`timescale 1ns/1ps
module test_pcrb_bank;
    import pcrb_pkg::*;
    // ========================================
    // Signals
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic lockout = 1'b0;
    logic warmN = 1'b1;
    logic porOut = 1'b0;
    logic vbLow = 1'b0;
    logic [3:0] pins = 4'hF;
    logic [7:0] railLow = 8'h00;
    logic [1:0] pfl = 2'b00;
    logic intOut;
    logic tcr = 1'b0;
    logic strap = 1'b1;
    pcrb_wr_t regWrite;
    logic rdStb;
    logic [7:0] rdAddr;
    logic [7:0] rdData;
    logic [7:0] railOn;
    pcrb_mode_t mode;
    logic go;
    logic fromStrap;
    logic strapHi;
    logic [2:0] disch;
    logic [7:0] flags;
    logic intOe;
    logic [7:0] expQ[$];
    logic rdP1 = 1'b0;
    logic rdP2 = 1'b0;
    int fails = 0;
    int totalChecks = 0;
    int cycles = 0;
    logic [31:0] rnd = 32'h7150;
    logic [7:0] railBit[4] = '{8'h06, 8'h08, 8'h10, 8'h20};
    logic [7:0] ofs[4] = '{OFS_FAULT_MASK, OFS_SUPPLY_ENABLE, OFS_CONV_MODE, OFS_CONV_CONTROL};
    logic [7:0] dflt[4] = '{RST_FAULT_MASK, RST_SUPPLY_ENABLE, RST_CONV_MODE, RST_CONV_CONTROL};
    // ========================================
    // Clock
    always #2.5 clock = ~clock;
    // Design and host
    pcrb_bank u_pcrb_bank (.clock(clock), .reset_n(reset_n),
        .supply_undervoltage_lockout(lockout), .warm_reset_pin_n(warmN),
        .power_on_reset_out(porOut), .backup_supply_low(vbLow), .regWrite(regWrite),
        .readStrobe(rdStb), .readAddr(rdAddr), .readData_q(rdData),
        .core_buck_enable_pin(pins[3]), .buck_two_enable_pin(pins[2]),
        .buck_three_enable_pin(pins[1]), .linear_reg_enable_pin(pins[0]),
        .railLowRaw(railLow), .power_fail_flag(pfl[1]), .low_battery_flag(pfl[0]),
        .targetCodeReached(tcr), .core_default_strap(strap), .railOn_q(railOn),
        .convMode_q(mode), .dynamic_voltage_transition_q(go), .coreFromStrap_q(fromStrap),
        .coreStrapHigh_q(strapHi), .dischargeEn_q(disch), .power_bad_flags_q(flags),
        .interruptOut_q(intOut), .interruptOe_q(intOe));
    pcrb_host u_pcrb_host (.clock(clock), .regWrite(regWrite), .readStrobe(rdStb),
        .readAddr(rdAddr));
    // ========================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : lfsr
    task automatic cmp(input string what, input logic [7:0] got, input logic [7:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp
    task automatic chkRead(input logic [7:0] a, input logic [7:0] exp);
        expQ.push_back(exp);
        u_pcrb_host.readReg(a);
    endtask : chkRead
    task automatic waitc(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask : waitc
    task automatic chkDefaults();
        for (int i = 0; i < 4; i++)
            chkRead(ofs[i], dflt[i]);
    endtask : chkDefaults
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test
    // Read answer monitor: oldest note against settled read data
    always @(posedge clock)
    begin
        rdP1 <= rdStb;
        rdP2 <= rdP1;
    end
    always @(negedge clock)
        if (rdP2 === 1'b1)
            cmp("read", rdData, (expQ.size() > 0) ? expQ.pop_front() : ~rdData);
    // Hang guard
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            fails++;
            end_of_test();
        end
    end
    // ========================================
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        waitc(2);
        chkDefaults();
        chkRead(8'h07, UNMAPPED_READ);
        for (int i = 0; i < 8; i++)
        begin
            rnd = lfsr(rnd);
            u_pcrb_host.writeReg(OFS_FAULT_MASK, rnd[7:0]);
            chkRead(OFS_FAULT_MASK, rnd[7:0] & FLAG_USED);
            u_pcrb_host.writeReg(OFS_CONV_MODE, rnd[15:8]);
            chkRead(OFS_CONV_MODE, rnd[15:8]);
            u_pcrb_host.writeReg(OFS_CONV_CONTROL, rnd[23:16] & 8'h7F);
            chkRead(OFS_CONV_CONTROL, rnd[23:16] & 8'h47);
            waitc(1);
            cmp("mode", mode, rnd[15:8]);
            cmp("disch", {5'h0, disch}, {5'h0, rnd[18:16]});
            cmp("strap", {7'h0, fromStrap}, {7'h0, rnd[22]});
        end
        u_pcrb_host.writeReg(OFS_CONV_CONTROL, 8'h80);
        waitc(1);
        cmp("go", {7'h0, go}, 8'h01);
        @(posedge clock);
        tcr <= 1'b1;
        @(posedge clock);
        tcr <= 1'b0;
        chkRead(OFS_CONV_CONTROL, 8'h00);
        for (int k = 0; k < 3; k++)
        begin
            u_pcrb_host.writeReg(OFS_CONV_CONTROL, 8'h00);
            warmN <= (k != 0);
            porOut <= (k == 1);
            vbLow <= (k == 2);
            @(posedge clock);
            {warmN, porOut, vbLow} <= 3'b100;
            chkRead(OFS_CONV_CONTROL, RST_CONV_CONTROL);
        end
        waitc(1);
        cmp("strapHi", {7'h0, strapHi}, 8'h01);
        @(posedge clock);
        strap <= 1'b0;
        waitc(2);
        cmp("strapLo", {7'h0, strapHi}, 8'h00);
        u_pcrb_host.writeReg(OFS_SUPPLY_ENABLE, 8'h00);
        chkRead(OFS_SUPPLY_ENABLE, 8'hC1);
        waitc(1);
        cmp("railOff", railOn, 8'h00);
        cmp("noRail", {7'h0, intOe}, 8'h01);
        for (int j = 0; j < 4; j++)
        begin
            u_pcrb_host.writeReg(OFS_SUPPLY_ENABLE, 8'h00);
            @(posedge clock);
            pins[j] <= 1'b0;
            @(posedge clock);
            pins[j] <= 1'b1;
            chkRead(OFS_SUPPLY_ENABLE, 8'hC1 | railBit[j]);
            waitc(1);
            cmp("rail", railOn, railBit[j]);
        end
        u_pcrb_host.writeReg(OFS_FAULT_MASK, 8'h00);
        u_pcrb_host.writeReg(OFS_SUPPLY_ENABLE, 8'hFF);
        waitc(2);
        cmp("ok", {7'h0, intOe}, 8'h00);
        @(posedge clock);
        railLow <= 8'h02;
        waitc(3);
        cmp("flags", flags, 8'h02);
        cmp("fault", {7'h0, intOe}, 8'h01);
        cmp("intOut", {7'h0, intOut}, 8'h00);
        chkRead(OFS_POWER_BAD, 8'h02);
        waitc(1);
        cmp("release", {7'h0, intOe}, 8'h00);
        cmp("flagsKept", flags, 8'h02);
        @(posedge clock);
        railLow <= 8'h00;
        u_pcrb_host.writeReg(OFS_FAULT_MASK, 8'h02);
        railLow <= 8'h02;
        waitc(3);
        cmp("masked", {7'h0, intOe}, 8'h00);
        u_pcrb_host.writeReg(OFS_FAULT_MASK, 8'h00);
        waitc(2);
        cmp("unmasked", {7'h0, intOe}, 8'h01);
        u_pcrb_host.writeReg(OFS_SUPPLY_ENABLE, 8'hFD);
        waitc(2);
        cmp("ldoOff", flags, 8'h00);
        @(posedge clock);
        lockout <= 1'b1;
        repeat (2) @(posedge clock);
        lockout <= 1'b0;
        chkDefaults();
        @(posedge clock);
        railLow <= 8'h00;
        pfl <= 2'b11;
        waitc(3);
        cmp("pfMasked", {7'h0, intOe}, 8'h00);
        cmp("pfFlags", flags, 8'hC0);
        waitc(4);
        end_of_test();
    end
endmodule : test_pcrb_bank
